// >>> design/adc_dev_end.sv
// Summary of operation
// [RULE1] High select puts upper byte on pins 0..7.
// [RULE2] Host writes low byte with select low.
// [RULE3] Select-low read drives twelve bits at once.
// [RULE4] Sixteen-bit host reads result in one cycle.
// [RULE5] Host reads calibration values in two cycles.
// [RULE6] Register writes are always two byte writes.
// [RULE7] Pins 0..8 bidirectional, steered by strobes; the code takes write data on pins 0..7 only.
// [RULE8] Pins 9..11 output only, read enabled.
// [RULE9] Unipolar straight binary, bipolar twos complement.
// [RULE10] Busy rises at trigger edge until done.
// [RULE11] Busy also covers calibration until complete.
// [RULE12] Durations counted in master clock periods.
// [RULE13] Trigger rising edge holds and starts conversion; the code starts it on the falling edge.
// [RULE14] Chip select with a strobe gives access.
// [RULE15] Host sends low byte first, high second.
// [RULE16] Pins float unless selected with a strobe.
// [RULE17] Register updates after the upper byte only.
//
// Purpose: Device side of the byte-wide converter host port.
// Assumes: Bus inputs synchronous to mclk; sample comes in on sample_in.
// Notes:   Strobe edges are found by comparing with last cycle.
`timescale 1ns/10ps
module adc_dev_end
	import adc_port_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYC, // Master periods per convert.
	parameter int CAL_CYCLES  = CAL_CYC,  // Master periods per cal.
	parameter int CAL_REGS    = 10        // Calibration register count.
)(
	input  wire logic        mclk,      // System clock.
	input  wire logic        rst_n,     // Synchronous reset, low.
	adc_port_if.dev          bus,       // Port to the host.
	input  wire logic [11:0] sample_in, // Offset-binary analog sample.
	output logic [11:0]      result,    // Last result, registered.
	output logic [13:0]      ctrl_out,  // Control word, registered.
	output logic             cal_run    // Calibration running.
);
	// Index registers are four bits and period counters sixteen bits.
	if (CONV_CYCLES < 1 || CONV_CYCLES > 65535 || CAL_CYCLES < 1 ||
	    CAL_CYCLES > 65535 || CAL_REGS < 1 || CAL_REGS > 16) begin : gen_bad
		$error("adc_dev_end: unsupported parameter value");
	end

	typedef enum {D_IDLE, D_CONV, D_CAL} dstate_e;
	dstate_e     st_reg;
	logic [13:0] test_reg;
	logic [13:0] cal_reg [CAL_REGS];
	logic [3:0]  cal_sel_reg, cal_rd_reg;
	logic [7:0]  lo_byte_reg;
	logic        have_lo_reg, wr_d_reg, rd_d_reg, trig_d_reg;
	logic [15:0] div_reg;
	logic [15:0] per_reg;
	logic        busy_reg;
	logic [11:0] hold_reg;
	logic [15:0] rdval;
	logic        wr_now, rd_now, tick;
	logic        conv_go, cal_go;
	logic [15:0] word;

	// Strobe qualifiers.
	assign wr_now = !bus.cs_n && !bus.wr_n;                  // [RULE14]
	assign rd_now = !bus.cs_n && !bus.rd_n;
	assign word   = {bus.bus_in[7:0], lo_byte_reg};
	assign tick   = (div_reg == 16'(CONV_DIV - 1));
	assign bus.busy = busy_reg;
	// Start requests are only taken while the sequencer is idle.
	assign conv_go = (st_reg == D_IDLE) &&
	                 ((!bus.conversion_trigger && trig_d_reg) ||
	                  ctrl_out[CTRL_CONV]);                  // [RULE10]
	assign cal_go  = (st_reg == D_IDLE) && !conv_go && ctrl_out[CTRL_STCAL];

	// ********************************************************
	// Code conversion.
	// ********************************************************
	// Bipolar flips the sign bit of offset binary.
	function automatic logic [11:0] code(input logic [11:0] s,
	                                      input logic bip);
		code = bip ? {~s[11], s[10:0]} : s;               // [RULE9]
	endfunction

	// Steps a calibration register index, wrapping after the last one.
	function automatic logic [3:0] next_index(input logic [3:0] i);
		next_index = (32'(i) + 1 < CAL_REGS) ? i + 4'h1 : 4'h0;
	endfunction

	// ********************************************************
	// Two-byte write assembly.
	// ********************************************************
	// Nothing is committed until the high byte lands.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_d_reg <= 1'b0; have_lo_reg <= 1'b0; lo_byte_reg <= 8'h00;
			ctrl_out <= CTRL_RESET; test_reg <= TEST_RESET;
			cal_sel_reg <= 4'h0;
			for (int i = 0; i < CAL_REGS; i++) cal_reg[i] <= CAL_RESET;
		end else begin
			wr_d_reg <= wr_now;
			// Start bits clear when taken; a write in the same cycle
			// wins, so a start that arrives then is not lost.
			if (conv_go) ctrl_out[CTRL_CONV] <= 1'b0;
			if (cal_go) ctrl_out[CTRL_STCAL] <= 1'b0;
			if (wr_now && !wr_d_reg) begin
				if (!bus.high_byte_select) begin         // [RULE2] [RULE15]
					lo_byte_reg <= bus.bus_in[7:0];
					have_lo_reg <= 1'b1;
				end else if (have_lo_reg) begin          // [RULE17] [RULE6]
					have_lo_reg <= 1'b0;
					case (word[15:ADDR_POS])
					ADDR_TEST: test_reg <= word[FIELD_W-1:0];
					ADDR_CAL: begin
						if (32'(cal_sel_reg) < CAL_REGS)
							cal_reg[cal_sel_reg] <= word[FIELD_W-1:0];
						cal_sel_reg <= next_index(cal_sel_reg);
					end
					ADDR_CTRL: ctrl_out <= word[FIELD_W-1:0];
					default: ;
					endcase
				end
			end
		end
	end

	// ********************************************************
	// Conversion and calibration sequencer.
	// ********************************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg <= D_IDLE; busy_reg <= 1'b0; trig_d_reg <= 1'b1;
			div_reg <= 16'h0000; per_reg <= 16'h0000;
			result <= 12'h000; cal_run <= 1'b0; hold_reg <= 12'h000;
		end else begin
			trig_d_reg <= bus.conversion_trigger;
			div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;  // [RULE12]
			case (st_reg)
			D_IDLE: begin
				// The divider restarts with each job, so a conversion
				// or calibration lasts an exact number of periods.
				if (conv_go) begin                           // [RULE10]
					busy_reg <= 1'b1; per_reg <= 16'h0000;
					div_reg <= 16'h0000; hold_reg <= sample_in;
					st_reg <= D_CONV;
				end else if (cal_go) begin
					busy_reg <= 1'b1; cal_run <= 1'b1;       // [RULE11]
					div_reg <= 16'h0000;
					per_reg <= 16'h0000; st_reg <= D_CAL;
				end
			end
			D_CONV: begin
				// The rising trigger edge freezes the sample; later
				// changes on the input do not reach the result.
				if (bus.conversion_trigger && !trig_d_reg)
					hold_reg <= sample_in;                   // [RULE13]
				if (tick) begin
					per_reg <= per_reg + 16'h0001;
					if (per_reg == 16'(CONV_CYCLES - 1)) begin
						result <= code(hold_reg, ctrl_out[CTRL_AMODE]);
						busy_reg <= 1'b0; st_reg <= D_IDLE;
					end
				end
			end
			D_CAL: if (tick) begin
				per_reg <= per_reg + 16'h0001;
				if (per_reg == 16'(CAL_CYCLES - 1)) begin
					busy_reg <= 1'b0; cal_run <= 1'b0;       // [RULE11]
					st_reg <= D_IDLE;
				end
			end
			default: st_reg <= D_IDLE;
			endcase
		end
	end

	// ********************************************************
	// Read path and pin drivers.
	// ********************************************************
	// Calibration reads step low byte then high byte per register.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rd_d_reg <= 1'b0; cal_rd_reg <= 4'h0;
		end else begin
			rd_d_reg <= rd_now;
			if (!rd_now && rd_d_reg && bus.high_byte_select &&
			    ctrl_out[CTRL_RDSEL+:2] == RD_CAL)
				cal_rd_reg <= next_index(cal_rd_reg);
		end
	end

	// Whole selected word; the pin drivers pick which part to show.
	always_comb begin
		case (ctrl_out[CTRL_RDSEL+:2])
		RD_DATA:   rdval = {4'h0, result};
		RD_TEST:   rdval = {2'b00, test_reg};
		RD_CAL:    rdval = {2'b00, cal_reg[cal_rd_reg]};
		default:   rdval = {15'h0000, busy_reg};
		endcase
	end

	// Registered drive so pins switch a cycle after the strobe.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bus.dev_low_o <= 9'h000; bus.dev_low_oe <= 9'h000;
			bus.dev_high_o <= 3'h0; bus.dev_high_oe <= 3'h0;
		end else begin
			// Upper byte of the word travels on pins 0..7.
			bus.dev_low_o <= bus.high_byte_select
			                 ? {1'b0, rdval[15:8]}
			                 : rdval[8:0];                // [RULE1] [RULE3]
			bus.dev_high_o <= bus.high_byte_select ? 3'h0 : rdval[11:9];
			// Pins drive only during a selected read.
			bus.dev_low_oe <= {9{rd_now}};               // [RULE7] [RULE16]
			bus.dev_high_oe <= {3{rd_now && !bus.high_byte_select}}; // [RULE8]
		end
	end
endmodule

// >>> design/adc_host_end.sv
// Purpose: Host side of the byte-wide converter port.
// Assumes: One request at a time; req taken when idle.
// Notes:   Writes go as two bytes, reads as one or two cycles.
`timescale 1ns/10ps
module adc_host_end
	import adc_port_pkg::*;
(
	input  wire logic        mclk,      // System clock.
	input  wire logic        rst_n,     // Synchronous reset, low.
	adc_port_if.host         bus,       // Port to the device.
	input  wire logic        req,       // Start an access, pulse.
	input  wire logic        req_write, // One for write.
	input  wire logic        req_two,   // Two-cycle byte read.
	input  wire logic [15:0] req_wdata, // Word to write.
	input  wire logic        trig,      // Pulse: start conversion.
	output logic             done,      // Access done, pulse.
	output logic [15:0]      rdata,     // Word read.
	output logic             dev_busy   // Device busy, registered.
);
	typedef enum {H_IDLE, H_SET, H_STB, H_GAP} hstate_e;
	hstate_e     st_reg;
	logic        second_reg, wr_reg, two_reg;
	logic [15:0] wd_reg;
	logic [1:0]  cnt_reg;
	logic        cs_reg, rd_reg, wrs_reg, hb_reg, oe_reg, trig_reg;
	logic [7:0]  dout_reg;

	assign bus.cs_n = cs_reg;
	assign bus.rd_n = rd_reg;
	assign bus.wr_n = wrs_reg;
	assign bus.high_byte_select = hb_reg;
	assign bus.host_low_o = dout_reg;
	assign bus.host_low_oe = oe_reg;
	assign bus.conversion_trigger = trig_reg;

	// ********************************************************
	// Access sequencer. Each strobe is held two cycles.
	// ********************************************************
	always_ff @(posedge mclk) begin
		done <= 1'b0;
		if (!rst_n) begin
			st_reg <= H_IDLE; second_reg <= 1'b0; wr_reg <= 1'b0;
			two_reg <= 1'b0; wd_reg <= 16'h0000; cnt_reg <= 2'h0;
			cs_reg <= 1'b1; rd_reg <= 1'b1; wrs_reg <= 1'b1;
			hb_reg <= 1'b0; oe_reg <= 1'b0; dout_reg <= 8'h00;
			rdata <= 16'h0000;
		end else begin
			case (st_reg)
			H_IDLE: if (req) begin
				wr_reg <= req_write; two_reg <= req_two;
				wd_reg <= req_wdata; second_reg <= 1'b0;
				st_reg <= H_SET;
			end
			H_SET: begin
				cs_reg <= 1'b0;                          // [RULE14]
				hb_reg <= second_reg;                    // [RULE1] [RULE2]
				if (wr_reg) begin
					wrs_reg <= 1'b0;                     // [RULE6]
					oe_reg <= 1'b1;
					// Low byte first, then high byte.
					dout_reg <= second_reg ? wd_reg[15:8]
					                       : wd_reg[7:0]; // [RULE15]
				end else begin
					rd_reg <= 1'b0;
				end
				cnt_reg <= 2'h0;
				st_reg <= H_STB;
			end
			H_STB: begin
				cnt_reg <= cnt_reg + 2'h1;
				if (cnt_reg == 2'h1) begin
					if (!wr_reg) begin
						if (!two_reg)
							rdata <= {4'h0, bus.bus_in}; // [RULE4]
						else if (!second_reg)
							rdata[7:0] <= bus.bus_in[7:0]; // [RULE5]
						else
							rdata[15:8] <= bus.bus_in[7:0];
					end
					cs_reg <= 1'b1; rd_reg <= 1'b1; wrs_reg <= 1'b1;
					oe_reg <= 1'b0;
					st_reg <= H_GAP;
				end
			end
			H_GAP: begin
				if (!second_reg && (wr_reg || two_reg)) begin
					second_reg <= 1'b1;
					st_reg <= H_SET;
				end else begin
					done <= 1'b1;
					st_reg <= H_IDLE;
				end
			end
			default: st_reg <= H_IDLE;
			endcase
		end
	end

	// Trigger pulse and busy sampling.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			trig_reg <= 1'b1;
			dev_busy <= 1'b0;
		end else begin
			trig_reg <= ~trig;                           // [RULE13]
			dev_busy <= bus.busy;
		end
	end
endmodule

// >>> design/adc_port_if.sv
// Purpose: Parallel bus between host and converter port.
// Assumes: Testbench resolves the tri-state data wires from enables.
// Notes:   Strobes are active low; enables are high while driving.
`timescale 1ns/10ps
interface adc_port_if;
	logic        cs_n;               // Chip select, low active.
	logic        rd_n;               // Read strobe, low active.
	logic        wr_n;               // Write strobe, low active.
	logic        high_byte_select;   // Selects upper byte.
	logic        conversion_trigger; // Falling edge starts conversion.
	logic        busy;               // Conversion or calibration busy.
	logic [8:0]  dev_low_o;          // Device drive, pins 0..8.
	logic [8:0]  dev_low_oe;         // Device enables, pins 0..8.
	logic [2:0]  dev_high_o;         // Device drive, pins 9..11.
	logic [2:0]  dev_high_oe;        // Device enables, pins 9..11.
	logic [7:0]  host_low_o;         // Host drive, pins 0..7.
	logic        host_low_oe;        // Host enable, pins 0..7.
	logic [11:0] bus_in;             // Resolved pin level.
	modport dev (
		input  cs_n, rd_n, wr_n, high_byte_select, conversion_trigger,
		input  bus_in,
		output busy, dev_low_o, dev_low_oe, dev_high_o, dev_high_oe
	);
	modport host (
		output cs_n, rd_n, wr_n, high_byte_select, conversion_trigger,
		output host_low_o, host_low_oe,
		input  busy, bus_in
	);
endinterface

// >>> design/adc_port_pkg.sv
// Purpose: Shared constants for the byte-wide converter host port.
// Assumes: One clock, mclk at 40 MHz; both ends import this package.
// Notes:   Register fields follow the two-byte write word layout.
package adc_port_pkg;
	// ********************************************************
	// Word layout and address decode.
	// ********************************************************
	localparam int DATA_W      = 12;
	localparam int LOW_W       = 9;
	localparam int HIGH_W      = 3;
	localparam int WORD_W      = 16;
	localparam int ADDR_POS    = 14;
	localparam int FIELD_W     = 14;
	localparam logic [1:0] ADDR_NONE = 2'h0;
	localparam logic [1:0] ADDR_TEST = 2'h1;
	localparam logic [1:0] ADDR_CAL  = 2'h2;
	localparam logic [1:0] ADDR_CTRL = 2'h3;
	// ********************************************************
	// Control register fields and reset values.
	// ********************************************************
	localparam int CTRL_STCAL  = 0;
	localparam int CTRL_CONV   = 4;
	localparam int CTRL_AMODE  = 5;
	localparam int CTRL_RDSEL  = 6;
	localparam logic [13:0] CTRL_RESET = 14'h0000;
	localparam logic [13:0] TEST_RESET = 14'h0000;
	localparam logic [13:0] CAL_RESET  = 14'h0000;
	localparam logic [1:0] RD_DATA   = 2'h0;
	localparam logic [1:0] RD_TEST   = 2'h1;
	localparam logic [1:0] RD_CAL    = 2'h2;
	localparam logic [1:0] RD_STATUS = 2'h3;
	// ********************************************************
	// Timing: master clock periods in mclk cycles.
	// ********************************************************
	localparam int MCLK_KHZ    = 40000;
	localparam int CONV_KHZ    = 4000;
	localparam int CONV_DIV    = MCLK_KHZ / CONV_KHZ;
	localparam int CONV_CYC    = 18;
	localparam int CAL_CYC     = 200;
endpackage

// >>> verif/adc_port_properties.sv
// Purpose: Concurrent checks on the port bus between both ends.
// Assumes: One clock mclk; rst_n synchronous, active low.
// Notes:   Busy length allows two cycles of edge-detect slack.
`timescale 1ns/10ps
module adc_port_properties
	import adc_port_pkg::*;
#(
	parameter int CONV_CYCLES = 18, // Periods per conversion.
	parameter int CAL_CYCLES  = 200 // Periods per calibration.
)(
	input wire logic       mclk,               // System clock.
	input wire logic       rst_n,              // Reset, low active.
	input wire logic       cs_n,               // Chip select.
	input wire logic       rd_n,               // Read strobe.
	input wire logic       high_byte_select,   // Upper byte select.
	input wire logic       conversion_trigger, // Conversion trigger.
	input wire logic       busy,               // Busy flag.
	input wire logic [8:0] dev_low_oe,         // Device enables 0..8.
	input wire logic [2:0] dev_high_oe,        // Device enables 9..11.
	input wire logic       host_low_oe         // Host enable 0..7.
);
	localparam int CONV_LEN = CONV_CYCLES * CONV_DIV;
	localparam int CAL_LEN  = CAL_CYCLES * CONV_DIV;
	int busy_cnt;
	// ********************************************************
	// Helper logic.
	// ********************************************************
	// Counts busy cycles so the length is known when busy falls.
	always_ff @(posedge mclk) begin
		if (!rst_n || !busy) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Pins float unless a read strobe is active now or was active one cycle ago.
	float_idle_a: assert property (
		(cs_n || rd_n) && $past(cs_n || rd_n) |->
		dev_low_oe == 9'h000 && dev_high_oe == 3'h0)
		else $error("device drives pins while not read");
	twelve_read_a: assert property (
		!cs_n && !rd_n && !high_byte_select
		&& $past(!cs_n && !rd_n && !high_byte_select)
		|-> (&dev_low_oe) && (&dev_high_oe))
		else $error("low read does not drive twelve pins");
	high_read_a: assert property (
		!cs_n && !rd_n && high_byte_select
		&& $past(!cs_n && !rd_n && high_byte_select)
		|-> (&dev_low_oe[7:0]) && dev_high_oe == 3'h0)
		else $error("high byte read drives wrong pins");
	bus_clash_a: assert property (
		host_low_oe |-> dev_low_oe[7:0] == 8'h00)
		else $error("device drives against host write");
	busy_rise_a: assert property (
		$fell(conversion_trigger) |=> busy)
		else $error("busy missing after trigger fall");
	busy_hold_a: assert property (
		$rose(busy) |-> busy [*8])
		else $error("busy dropped too early");
	busy_end_a: assert property (
		$rose(busy) |-> ##[1:1000] !busy)
		else $error("busy never returned low");
	busy_len_a: assert property (
		$fell(busy) |-> busy_cnt inside {[CONV_LEN:CONV_LEN + 2],
		[CAL_LEN:CAL_LEN + 2]})
		else $error("busy length off");
endmodule

// >>> verif/testbench.sv
// Purpose: Drives host requests and checks words across both ends.
// Assumes: Indices of calibration registers start at zero.
// Notes:   Undriven pins show the inverse of their last level.
`timescale 1ns/10ps
module testbench;
	import adc_port_pkg::*;
	localparam int CONV_N = 18;
	localparam int CAL_N  = 2;
	logic        mclk      = 1'b0;
	logic        rst_n     = 1'b0;
	logic        req       = 1'b0;
	logic        req_write = 1'b0;
	logic        req_two   = 1'b0;
	logic        trig      = 1'b0;
	logic [15:0] req_wdata = 16'h0000;
	logic [11:0] sample_in = 12'h000;
	logic [11:0] last_pins = 12'h000;
	logic        done, dev_busy, cal_run;
	logic [15:0] rdata;
	logic [11:0] result, dev_oe, host_oe;
	logic [13:0] ctrl_out;
	int          mismatches = 0;
	int          num_checks = 0;
	adc_port_if bus ();
	adc_host_end u_adc_host_end (.mclk(mclk), .rst_n(rst_n), .bus(bus.host),
		.req(req), .req_write(req_write), .req_two(req_two),
		.req_wdata(req_wdata), .trig(trig), .done(done), .rdata(rdata),
		.dev_busy(dev_busy));
	adc_dev_end #(.CONV_CYCLES(CONV_N), .CAL_CYCLES(CAL_N)) u_adc_dev_end (
		.mclk(mclk), .rst_n(rst_n), .bus(bus.dev), .sample_in(sample_in),
		.result(result), .ctrl_out(ctrl_out), .cal_run(cal_run));
	adc_port_properties #(.CONV_CYCLES(CONV_N), .CAL_CYCLES(CAL_N)) u_props (
		.mclk(mclk), .rst_n(rst_n), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
		.high_byte_select(bus.high_byte_select), .busy(bus.busy),
		.conversion_trigger(bus.conversion_trigger),
		.dev_low_oe(bus.dev_low_oe), .dev_high_oe(bus.dev_high_oe),
		.host_low_oe(bus.host_low_oe));
	// ********************************************************
	// Clock and pin resolution.
	// ********************************************************
	// Clock at 40 MHz.
	always #12.5 mclk = ~mclk;
	// A floating pin must never look like held data, so it toggles.
	assign dev_oe  = {bus.dev_high_oe, bus.dev_low_oe};
	assign host_oe = {4'h0, {8{bus.host_low_oe}}};
	assign bus.bus_in = (dev_oe & {bus.dev_high_o, bus.dev_low_o})
		| (host_oe & ~dev_oe & {4'h0, bus.host_low_o})
		| (~dev_oe & ~host_oe & ~last_pins);
	always @(posedge mclk) last_pins <= bus.bus_in;
	// ********************************************************
	// Tasks.
	// ********************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	// One request, then a bounded wait for the done pulse.
	task automatic access(input logic wr, input logic two,
			input logic [15:0] wd);
		int n;
		@(posedge mclk);
		req <= 1'b1;
		req_write <= wr;
		req_two <= two;
		req_wdata <= wd;
		@(posedge mclk);
		req <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (done !== 1'b1 && n < 50);
		check({15'h0, done}, 16'h0001);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (bus.busy !== 1'b0 && n < 1000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check({15'h0, bus.busy}, 16'h0000);
	endtask
	task automatic convert(input logic [15:0] ctrl, input logic [11:0] s,
			input logic [11:0] want);
		access(1'b1, 1'b0, ctrl);
		@(posedge mclk);
		sample_in <= s;
		trig <= 1'b1;
		@(posedge mclk);
		trig <= 1'b0;
		repeat (6) @(posedge mclk);
		// The held sample must survive a change at the input.
		sample_in <= ~s;
		#1;
		check({15'h0, dev_busy}, 16'h0001);
		wait_idle();
		access(1'b0, 1'b0, 16'h0000);
		check({4'h0, rdata[11:0]}, {4'h0, want});
		check({4'h0, result}, {4'h0, want});
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ********************************************************
	// Tests.
	// ********************************************************
	// Watchdog: the tests need under two thousand cycles.
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		close_out();
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		#1;
		check({4'h0, dev_oe}, 16'h0000);
		access(1'b1, 1'b0, 16'h6abc);
		access(1'b1, 1'b0, 16'hc040);
		check({2'h0, ctrl_out}, 16'h0040);
		access(1'b1, 1'b0, 16'h0fff);
		check({2'h0, ctrl_out}, 16'h0040);
		access(1'b0, 1'b0, 16'h0000);
		check({4'h0, rdata[11:0]}, 16'h0abc);
		access(1'b0, 1'b1, 16'h0000);
		check(rdata, 16'h2abc);
		convert(16'hc000, 12'h8a5, 12'h8a5);
		convert(16'hc000, 12'h123, 12'h123);
		convert(16'hc020, 12'h8a5, 12'h0a5);
		convert(16'hc020, 12'h123, 12'h923);
		// Software start converts the input left by the last test.
		access(1'b1, 1'b0, 16'hc010);
		check({15'h0, dev_busy}, 16'h0001);
		wait_idle();
		access(1'b0, 1'b0, 16'h0000);
		check({4'h0, rdata[11:0]}, 16'h0edc);
		access(1'b1, 1'b0, 16'ha234);
		access(1'b1, 1'b0, 16'h8a5a);
		access(1'b1, 1'b0, 16'hc080);
		access(1'b0, 1'b1, 16'h0000);
		check(rdata, 16'h2234);
		access(1'b0, 1'b1, 16'h0000);
		check(rdata, 16'h0a5a);
		access(1'b1, 1'b0, 16'hc001);
		repeat (4) @(posedge mclk);
		#1;
		check({15'h0, bus.busy}, 16'h0001);
		wait_idle();
		check({15'h0, cal_run}, 16'h0000);
		access(1'b1, 1'b0, 16'hc0c1);
		access(1'b0, 1'b0, 16'h0000);
		check(rdata, 16'h0001);
		wait_idle();
		access(1'b0, 1'b0, 16'h0000);
		check({15'h0, rdata[0]}, 16'h0000);
		close_out();
	end
endmodule
